// ---- indep_watchdog_regs.svh ----
// Offsets, field positions, reset values and timing counts of the
// independent watchdog. Included by the design file and the test bench.
//
// Summary of operation
// - Count clock is dedicated clock divided by selection
// - Fourteen-bit down-counter, one step per divided clock
// - Counting starts by itself after reset
// - Reset stops counting, restores all registers
// - Underflow or refresh error restarts count automatically
// - Refresh window bounded by start and end
// - Refresh outside window raises refresh error
// - One bit picks reset or interrupt output
// - Software reads counter through status register
// - Separate underflow and refresh error event outputs
// - Optional count stop in low-power modes
// - Division ratio from boot word four-bit field
// - Timeout from boot word two-bit field
// - Window start and end from boot word
// - Boot word start bit clear starts it; security attribute settable
`ifndef INDEP_WATCHDOG_REGS_SVH
`define INDEP_WATCHDOG_REGS_SVH

// Register offsets (byte addresses, one word each)
`define WD_OFS_REFRESH   8'h00
`define WD_OFS_STATUS    8'h04
`define WD_OFS_IRQ_STAT  8'h08
`define WD_OFS_IRQ_MASK  8'h0C
`define WD_OFS_SECURITY  8'h10

// Refresh key sequence: first then second
`define WD_KEY_FIRST     8'h00
`define WD_KEY_SECOND    8'hFF

// Boot option word field positions
`define BOW_DIV_LSB      4
`define BOW_TOPS_LSB     2
`define BOW_RPES_LSB     8
`define BOW_RPSS_LSB     12
`define BOW_RSTIRQ_BIT   16
`define BOW_STPCTL_BIT   17
`define BOW_START_BIT    1

// Status bits
`define WD_ST_UNDERFLOW  0
`define WD_ST_REFERR     1

// Reset values
`define WD_CNT_RESET     14'h3FFF
`define WD_MASK_RESET    2'b00
`define WD_SEC_RESET     1'b1

// Length of the reset/interrupt pulse in system clocks
`define WD_PULSE_NS      100
`define WD_CLK_NS        25
`define WD_PULSE_CYC     (`WD_PULSE_NS / `WD_CLK_NS)

`endif

// ---- indep_watchdog_pkg.sv ----
// Types shared by the independent watchdog design.
package indep_watchdog_pkg;

   typedef struct packed {
      logic [3:0] div_sel;
      logic [1:0] timeout_sel;
      logic [1:0] win_start_sel;
      logic [1:0] win_end_sel;
      logic       reset_or_irq;
      logic       lowpower_stop;
      logic       auto_start;
   } wd_config_type;

   typedef struct packed {
      logic underflow;
      logic refresh_err;
   } wd_event_type;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_COUNT,
      ST_RESTART
   } wd_state_type;

endpackage

// ---- indep_watchdog.sv ----
// Independent watchdog: count-clock divider, down-counter with refresh
// window, event, reset and interrupt outputs, small register port.
// Assumes the dedicated clock arrives as a pin and the boot word is stable
// from reset release onward; all logic runs on the system clock.
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "indep_watchdog_regs.svh"

module indep_watchdog (
   // Clock and reset
   input  wire  logic        clk_sys_in,
   input  wire  logic        sys_rst_in,
   // Dedicated watchdog clock, from outside
   input  wire  logic        wd_dedicated_clk_in,
   // Boot option word and low-power state
   input  wire  logic [31:0] boot_option_word0_in,
   input  wire  logic        sleep_mode_in,
   input  wire  logic        sw_standby_in,
   input  wire  logic        snooze_in,
   // Security of the party that writes
   input  wire  logic        bus_secure_in,
   // Register port
   input  wire  logic [7:0]  addr_in,
   input  wire  logic [31:0] wdata_in,
   input  wire  logic        wr_in,
   input  wire  logic        rd_in,
   output logic       [31:0] rdata_out,
   // Watchdog outputs
   output logic              wd_reset_out,
   output logic              wd_nmi_out,
   output logic              irq_out,
   output logic              evt_underflow_out,
   output logic              evt_refresh_err_out,
   output logic              sleep_count_stop_out,
   output logic              secure_attr_out
);

   // Two-stage sync of the dedicated clock, then edge detection
   logic       wclk_s1_q;
   logic       wclk_s2_q;
   logic       wclk_s3_q;
   logic [8:0] pre_q;
   logic [8:0] pre_d;
   logic [13:0] cnt_q;
   logic [13:0] cnt_d;
   logic       key_q;
   logic       key_d;
   logic [1:0] stat_q;
   logic [1:0] stat_d;
   logic [1:0] mask_q;
   logic [1:0] mask_d;
   logic       sec_q;
   logic       sec_d;
   logic [2:0] pulse_q;
   logic [2:0] pulse_d;
   logic       sel_q;
   logic       sel_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic       evt_uf_q;
   logic       evt_re_q;
   indep_watchdog_pkg::wd_config_type cfg_q;
   indep_watchdog_pkg::wd_state_type  state_q;
   indep_watchdog_pkg::wd_state_type  state_d;
   indep_watchdog_pkg::wd_event_type  evt;

   // Division ratio as a mask on the prescaler; unknown codes divide by 1
   function automatic logic [8:0] div_mask(input logic [3:0] sel);
      case (sel)
         4'h0:    div_mask = 9'h000;
         4'h2:    div_mask = 9'h00F;
         4'h3:    div_mask = 9'h01F;
         4'h4:    div_mask = 9'h03F;
         4'hF:    div_mask = 9'h07F;
         4'h5:    div_mask = 9'h0FF;
         default: div_mask = 9'h000;
      endcase
   endfunction

   // Two-bit selection to a count position: 1/16, 1/4, 1/2 or all of the span
   function automatic logic [13:0] top_val(input logic [1:0] sel);
      case (sel)
         2'h0:    top_val = 14'h03FF;
         2'h1:    top_val = 14'h0FFF;
         2'h2:    top_val = 14'h1FFF;
         default: top_val = 14'h3FFF;
      endcase
   endfunction

   // Window position as a fraction of the timeout: 75, 50, 25, 0/100 %
   function automatic logic [13:0] win_pos(input logic [13:0] top,
                                           input logic [1:0]  sel);
      case (sel)
         2'h0:    win_pos = top - (top >> 2);
         2'h1:    win_pos = top >> 1;
         2'h2:    win_pos = top >> 2;
         default: win_pos = 14'h0000;
      endcase
   endfunction

   wire [13:0] top_w     = top_val(cfg_q.timeout_sel);
   wire [13:0] win_hi_w  = (cfg_q.win_start_sel == 2'h3) ?
                           top_w : win_pos(top_w, cfg_q.win_start_sel);
   wire [13:0] win_lo_w  = win_pos(top_w, cfg_q.win_end_sel);
   wire        in_win_w  = (cnt_q <= win_hi_w) && (cnt_q >= win_lo_w);
   wire        lp_stop_w = cfg_q.lowpower_stop &&
                           (sleep_mode_in || sw_standby_in || snooze_in);
   wire        wclk_rise = wclk_s2_q && !wclk_s3_q;
   wire        tick_w    = wclk_rise &&
                           ((pre_q & div_mask(cfg_q.div_sel)) == 9'h000) &&
                           !lp_stop_w;
   wire        running_w = (state_q == indep_watchdog_pkg::ST_COUNT);
   wire        wr_ref_w  = wr_in && (addr_in == `WD_OFS_REFRESH);
   wire        wr_stat_w = wr_in && (addr_in == `WD_OFS_IRQ_STAT);
   wire        wr_mask_w = wr_in && (addr_in == `WD_OFS_IRQ_MASK);
   wire        wr_sec_w  = wr_in && (addr_in == `WD_OFS_SECURITY) &&
                           bus_secure_in;
   wire        ref_done  = wr_ref_w && key_q &&
                           (wdata_in[7:0] == `WD_KEY_SECOND);
   wire        ref_ok    = running_w && ref_done && in_win_w;
   wire        ref_err   = running_w && ref_done && !in_win_w;
   wire        underflow = running_w && tick_w && (cnt_q == 14'h0000);

   assign evt.underflow   = underflow;
   assign evt.refresh_err = ref_err;

   always_comb begin
      key_d = key_q;
      if (wr_ref_w) begin
         key_d = (wdata_in[7:0] == `WD_KEY_FIRST);
      end
   end

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         indep_watchdog_pkg::ST_IDLE: begin
            // A boot word with the start bit clear starts it, from either side
            if (cfg_q.auto_start) begin
               state_d = indep_watchdog_pkg::ST_COUNT;
               cnt_d   = top_w;
            end
         end
         indep_watchdog_pkg::ST_COUNT: begin
            if (underflow || ref_err) begin
               state_d = indep_watchdog_pkg::ST_RESTART;
            end else if (ref_ok) begin
               cnt_d = top_w;
            end else if (tick_w) begin
               cnt_d = cnt_q - 14'h0001;
            end
         end
         indep_watchdog_pkg::ST_RESTART: begin
            state_d = indep_watchdog_pkg::ST_COUNT;
            cnt_d   = top_w;
         end
         default: state_d = indep_watchdog_pkg::ST_IDLE;
      endcase
   end

   // Set wins over a write-one clear
   assign stat_d = (stat_q & ~(wr_stat_w ? wdata_in[1:0] : 2'b00)) |
                   {evt.refresh_err, evt.underflow};
   assign mask_d = wr_mask_w ? wdata_in[1:0] : mask_q;
   assign sec_d  = wr_sec_w ? wdata_in[0] : sec_q;
   assign pre_d  = wclk_rise ? pre_q + 9'h001 : pre_q;
   assign pulse_d = (underflow || ref_err) ? 3'(`WD_PULSE_CYC) :
                    (pulse_q != 3'h0) ? pulse_q - 3'h1 : 3'h0;
   assign sel_d  = (underflow || ref_err) ? cfg_q.reset_or_irq : sel_q;

   wire rd_stat_w = (addr_in == `WD_OFS_STATUS);
   wire rd_irqs_w = (addr_in == `WD_OFS_IRQ_STAT);
   wire rd_mask_w = (addr_in == `WD_OFS_IRQ_MASK);
   wire rd_sec_w  = (addr_in == `WD_OFS_SECURITY);

   always_comb begin
      rdata_d = 32'h0000_0000;
      if (rd_in && rd_stat_w) begin
         rdata_d = {18'h0_0000, cnt_q};
      end else if (rd_in && rd_irqs_w) begin
         rdata_d = {30'h0000_0000, stat_q};
      end else if (rd_in && rd_mask_w) begin
         rdata_d = {30'h0000_0000, mask_q};
      end else if (rd_in && rd_sec_w) begin
         rdata_d = {31'h0000_0000, sec_q};
      end
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         wclk_s1_q <= 1'b0;
         wclk_s2_q <= 1'b0;
         wclk_s3_q <= 1'b0;
      end else begin
         wclk_s1_q <= wd_dedicated_clk_in;
         wclk_s2_q <= wclk_s1_q;
         wclk_s3_q <= wclk_s2_q;
      end
   end

   // Boot word caught after release, not under the asynchronous reset
   logic cfg_taken_q;
   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cfg_q       <= '0;
         cfg_taken_q <= 1'b0;
      end else if (!cfg_taken_q) begin
         cfg_taken_q         <= 1'b1;
         cfg_q.div_sel       <= boot_option_word0_in[`BOW_DIV_LSB +: 4];
         cfg_q.timeout_sel   <= boot_option_word0_in[`BOW_TOPS_LSB +: 2];
         cfg_q.win_start_sel <= boot_option_word0_in[`BOW_RPSS_LSB +: 2];
         cfg_q.win_end_sel   <= boot_option_word0_in[`BOW_RPES_LSB +: 2];
         cfg_q.reset_or_irq  <= boot_option_word0_in[`BOW_RSTIRQ_BIT];
         cfg_q.lowpower_stop <= boot_option_word0_in[`BOW_STPCTL_BIT];
         cfg_q.auto_start    <= !boot_option_word0_in[`BOW_START_BIT];
      end
   end

   always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_q  <= indep_watchdog_pkg::ST_IDLE;
         cnt_q    <= `WD_CNT_RESET;
         pre_q    <= 9'h000;
         key_q    <= 1'b0;
         stat_q   <= 2'b00;
         mask_q   <= `WD_MASK_RESET;
         sec_q    <= `WD_SEC_RESET;
         pulse_q  <= 3'h0;
         sel_q    <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         evt_uf_q <= 1'b0;
         evt_re_q <= 1'b0;
      end else begin
         state_q  <= state_d;
         cnt_q    <= cnt_d;
         pre_q    <= pre_d;
         key_q    <= key_d;
         stat_q   <= stat_d;
         mask_q   <= mask_d;
         sec_q    <= sec_d;
         pulse_q  <= pulse_d;
         sel_q    <= sel_d;
         rdata_q  <= rdata_d;
         evt_uf_q <= evt.underflow;
         evt_re_q <= evt.refresh_err;
      end
   end

   // Selection bit set means reset, clear means interrupt
   assign wd_reset_out         = (pulse_q != 3'h0) && sel_q;
   assign wd_nmi_out           = (pulse_q != 3'h0) && !sel_q;
   assign irq_out              = |(stat_q & mask_q);
   assign evt_underflow_out    = evt_uf_q;
   assign evt_refresh_err_out  = evt_re_q;
   assign sleep_count_stop_out = cfg_q.lowpower_stop && sleep_mode_in;
   assign secure_attr_out      = sec_q;
   assign rdata_out            = rdata_q;

   // Event outputs follow their cause by one cycle
   AST_UF_EVENT: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      underflow |=> evt_underflow_out)
      else $error("underflow event lost");

   AST_RE_EVENT: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      ref_err |=> evt_refresh_err_out)
      else $error("refresh error lost");

   AST_UF_ONCE: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      evt_underflow_out |=> !evt_underflow_out)
      else $error("underflow event too long");

   AST_UF_STATUS: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      underflow |=> stat_q[`WD_ST_UNDERFLOW])
      else $error("underflow status not set");

   AST_RE_STATUS: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      ref_err |=> stat_q[`WD_ST_REFERR])
      else $error("refresh error status not set");

   // Restart takes one idle cycle, then counts from the top
   AST_RESTART: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      (underflow || ref_err) |=> ##1 (cnt_q == top_w) && running_w)
      else $error("no automatic restart");

   AST_RELOAD: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      ref_ok |=> cnt_q == $past(top_w))
      else $error("refresh no reload");

   AST_KEY_BREAK: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      (wr_ref_w && wdata_in[7:0] != `WD_KEY_FIRST) |=> !key_q)
      else $error("refresh key not broken");

   AST_DECREMENT: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      (running_w && tick_w && !ref_done && cnt_q != 14'h0000)
      |=> cnt_q == $past(cnt_q) - 14'h0001)
      else $error("no decrement");

   AST_HOLD: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      (running_w && !tick_w && !ref_done) |=> $stable(cnt_q))
      else $error("count moved without tick");

   AST_COUNT_TOP: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      running_w |-> cnt_q <= top_w)
      else $error("count above timeout");

   AST_TICK_EDGE: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      tick_w |-> wclk_rise)
      else $error("tick without clock edge");

   AST_LP_STOP: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      lp_stop_w |-> !tick_w)
      else $error("count in low power");

   // Only one of the two alarm outputs, for the full pulse
   AST_OUT_SEL: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      (underflow || ref_err) |=> (wd_reset_out == $past(cfg_q.reset_or_irq))
      && (wd_nmi_out != $past(cfg_q.reset_or_irq)))
      else $error("bad output");

   AST_PULSE_LEN: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      (underflow || ref_err) |=> (wd_reset_out || wd_nmi_out) [*4])
      else $error("alarm pulse too short");

   AST_ONE_OUT: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      !(wd_reset_out && wd_nmi_out))
      else $error("reset and interrupt together");

   // Window bounds are inclusive on both sides
   AST_WINDOW: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      (running_w && ref_done && cnt_q > win_hi_w) |-> ref_err)
      else $error("refresh outside window accepted");

   AST_WIN_LOW: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      (running_w && ref_done && cnt_q < win_lo_w) |-> ref_err)
      else $error("refresh below window accepted");

   AST_WIN_ACCEPT: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      (running_w && ref_done && in_win_w) |-> ref_ok)
      else $error("refresh inside window refused");

   AST_READ_COUNT: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      (rd_in && addr_in == `WD_OFS_STATUS)
      |=> rdata_out == {18'h0_0000, $past(cnt_q)})
      else $error("count read wrong");

   AST_SEC_GUARD: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      (wr_in && addr_in == `WD_OFS_SECURITY && !bus_secure_in)
      |=> $stable(secure_attr_out))
      else $error("nonsecure write took effect");

   // Boot settings must not move once captured
   AST_CFG_HOLD: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      cfg_taken_q |=> $stable(cfg_q))
      else $error("configuration changed");

   AST_AUTOSTART: assert property (@(posedge clk_sys_in)
      disable iff (sys_rst_in)
      $rose(cfg_taken_q) && cfg_q.auto_start |=> running_w)
      else $error("no auto start");

endmodule
`default_nettype wire

// ---- independent_watchdog_timer_test.sv ----
// Self-checking bench for the independent watchdog, random gaps from LFSR.
// Assumes the design header is on the include path; bench drives all pins.
`timescale 1ns/1ps
`default_nettype none
`include "indep_watchdog_regs.svh"
module independent_watchdog_timer_test;
   logic        clk_sys_in = 1'b0;
   logic        sys_rst_in = 1'b1;
   logic        wd_clk     = 1'b0;
   logic [1:0]  ph         = 2'h0;
   logic [31:0] boot       = 32'h0000_0000;
   logic [31:0] wdata      = 32'h0000_0000;
   logic [7:0]  addr       = 8'h00;
   logic        wr = 1'b0, rd = 1'b0, sec = 1'b0;
   logic        slp = 1'b0, stby = 1'b0, snz = 1'b0;
   logic [31:0] rdata;
   logic        rst_o, nmi_o, irq_o, ev_uf, ev_re, stop_o, attr_o;
   logic [31:0] seed       = 32'h0000_750F;
   int          n_mismatch = 0;
   int          n_tests    = 0;

   always #12.5 clk_sys_in = ~clk_sys_in;
   // Dedicated clock: two system cycles high, two low
   always @(posedge clk_sys_in) begin
      ph <= ph + 2'h1;
      if (ph[0]) wd_clk <= ~wd_clk;
   end

   indep_watchdog u_dut (
      .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
      .wd_dedicated_clk_in(wd_clk), .boot_option_word0_in(boot),
      .sleep_mode_in(slp), .sw_standby_in(stby), .snooze_in(snz),
      .bus_secure_in(sec), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .wd_reset_out(rst_o),
      .wd_nmi_out(nmi_o), .irq_out(irq_o), .evt_underflow_out(ev_uf),
      .evt_refresh_err_out(ev_re), .sleep_count_stop_out(stop_o),
      .secure_attr_out(attr_o));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   function automatic logic [31:0] bw(input logic [3:0] dv,
         input logic [1:0] to, st, en, input logic rs, sp);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[`BOW_DIV_LSB +: 4]  = dv;
      w[`BOW_TOPS_LSB +: 2] = to;
      w[`BOW_RPSS_LSB +: 2] = st;
      w[`BOW_RPES_LSB +: 2] = en;
      w[`BOW_RSTIRQ_BIT]    = rs;
      w[`BOW_STPCTL_BIT]    = sp;
      return w;
   endfunction

   function automatic int tval(input int s);
      case (s)
         0: return 32'h0000_03FF;
         1: return 32'h0000_0FFF;
         2: return 32'h0000_1FFF;
         default: return 32'h0000_3FFF;
      endcase
   endfunction

   task automatic check(input string what, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk_sys_in);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output int d);
      @(posedge clk_sys_in);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk_sys_in);
      rd <= 1'b0;
      #1 d = int'(rdata);
   endtask

   task automatic refresh();
      wr_reg(`WD_OFS_REFRESH, {24'h00_0000, `WD_KEY_FIRST});
      wr_reg(`WD_OFS_REFRESH, {24'h00_0000, `WD_KEY_SECOND});
   endtask

   task automatic reboot(input logic [31:0] w);
      @(posedge clk_sys_in);
      sys_rst_in <= 1'b1;
      boot <= w;
      repeat (8) @(posedge clk_sys_in);
      #1 check("reset outputs", {attr_o, rst_o, nmi_o, irq_o, ev_uf, ev_re},
               6'h20);
      @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
   endtask

   // Waits for an event pulse, then counts reset and interrupt pulse cycles
   task automatic wait_evt(input logic use_re, input int bound,
         input logic must, output logic found, output int nr, nn);
      int i;
      found = 1'b0;
      nr = 0;
      nn = 0;
      // Event may already stand when called right after a write
      #1;
      for (i = 0; i < bound && !found; i++) begin
         found = ((use_re ? ev_re : ev_uf) === 1'b1);
         if (!found) begin
            @(posedge clk_sys_in);
            #1;
         end
      end
      if (must && !found) begin
         n_mismatch++;
         $display("wait limit reached");
         give_verdict();
      end
      for (i = 0; i < 10 && found; i++) begin
         nr += (rst_o === 1'b1);
         nn += (nmi_o === 1'b1);
         @(posedge clk_sys_in);
         #1;
      end
   endtask

   initial begin
      int a, b, k, nr, nn, ex;
      logic found;
      static logic [3:0] dcode [6] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'hF, 4'h5};
      static int rat [6] = '{1, 16, 32, 64, 128, 256};
      for (k = 0; k < 4; k++) begin
         reboot(bw(4'h0, k[1:0], 2'h3, 2'h3, 1'b1, 1'b0));
         rd_reg(`WD_OFS_STATUS, a);
         check("start count", a <= tval(k) && a + 4 >= tval(k), 1'h1);
         repeat (20) @(posedge clk_sys_in);
         rd_reg(`WD_OFS_STATUS, b);
         check("counting down", b < a, 1'h1);
      end
      $display("test timeout start done");
      for (k = 0; k < 6; k++) begin
         reboot(bw(dcode[k], 2'h3, 2'h3, 2'h3, 1'b1, 1'b0));
         rd_reg(`WD_OFS_STATUS, a);
         repeat (2048) @(posedge clk_sys_in);
         rd_reg(`WD_OFS_STATUS, b);
         ex = 512 / rat[k];
         check("divided rate", a - b >= ex - 1 && a - b <= ex + 1, 1'h1);
      end
      $display("test division done");
      reboot(bw(4'h0, 2'h0, 2'h3, 2'h3, 1'b1, 1'b0));
      seed = lfsr(seed);
      repeat (200 + seed[5:0]) @(posedge clk_sys_in);
      refresh();
      wait_evt(1'b1, 8, 1'b0, found, nr, nn);
      check("error on valid refresh", found, 1'h0);
      rd_reg(`WD_OFS_STATUS, b);
      check("reload on refresh", b + 4 >= tval(0), 1'h1);
      seed = lfsr(seed);
      wr_reg({1'b1, seed[6:0]}, seed);
      rd_reg({1'b1, seed[6:0]}, a);
      check("unmapped read", a, 32'h0000_0000);
      $display("test refresh done");
      wait_evt(1'b0, 6000, 1'b1, found, nr, nn);
      check("reset pulse", nr, `WD_PULSE_CYC);
      check("no nmi pulse", nn, 32'h0000_0000);
      rd_reg(`WD_OFS_STATUS, b);
      check("restart after underflow", b + 12 >= tval(0), 1'h1);
      rd_reg(`WD_OFS_IRQ_STAT, a);
      check("underflow status", a, 32'h0000_0001);
      check("irq masked", irq_o, 1'h0);
      wr_reg(`WD_OFS_IRQ_MASK, 32'h0000_0003);
      @(posedge clk_sys_in);
      #1 check("irq unmasked", irq_o, 1'h1);
      wr_reg(`WD_OFS_IRQ_STAT, 32'h0000_0001);
      @(posedge clk_sys_in);
      #1 check("irq cleared", irq_o, 1'h0);
      $display("test underflow done");
      reboot(bw(4'h0, 2'h3, 2'h2, 2'h3, 1'b0, 1'b0));
      refresh();
      wait_evt(1'b1, 12, 1'b1, found, nr, nn);
      check("nmi pulse", nn, `WD_PULSE_CYC);
      check("no reset pulse", nr, 32'h0000_0000);
      rd_reg(`WD_OFS_IRQ_STAT, a);
      check("refresh error status", a, 32'h0000_0002);
      rd_reg(`WD_OFS_STATUS, b);
      check("restart after error", b + 12 >= tval(3), 1'h1);
      $display("test refresh error done");
      reboot(bw(4'h0, 2'h3, 2'h3, 2'h3, 1'b1, 1'b1));
      for (k = 0; k < 4; k++) begin
         @(posedge clk_sys_in);
         {snz, stby, slp} <= 3'h1 << k;
         repeat (3) @(posedge clk_sys_in);
         #1 check("stop output", stop_o, k == 0);
         rd_reg(`WD_OFS_STATUS, a);
         repeat (40) @(posedge clk_sys_in);
         rd_reg(`WD_OFS_STATUS, b);
         check("low-power hold", a == b, k < 3);
      end
      $display("test low power done");
      @(posedge clk_sys_in);
      sec <= 1'b0;
      wr_reg(`WD_OFS_SECURITY, 32'h0000_0000);
      @(posedge clk_sys_in);
      #1 check("nonsecure write", attr_o, 1'h1);
      sec <= 1'b1;
      wr_reg(`WD_OFS_SECURITY, 32'h0000_0000);
      @(posedge clk_sys_in);
      #1 check("secure write", attr_o, 1'h0);
      rd_reg(`WD_OFS_SECURITY, a);
      check("security readback", a, 32'h0000_0000);
      $display("test security done");
      give_verdict();
   end
endmodule
`default_nettype wire
